// *** sfc_pkg.sv ***
/*
 * constants for the serial flash instruction and status block: opcodes,
 * status bit layout, frame bit counts and timing figures.
 * assumes a 10 MHz system clock and a mode-0 spi link.
 */
package sfc_pkg;

    // instruction opcodes
    localparam logic [7:0] OP_WREN  = 8'h06;
    localparam logic [7:0] OP_VWREN = 8'h50;
    localparam logic [7:0] OP_WRDI  = 8'h04;
    localparam logic [7:0] OP_RDSR  = 8'h05;
    localparam logic [7:0] OP_WRSR  = 8'h01;
    localparam logic [7:0] OP_READ  = 8'h03;
    localparam logic [7:0] OP_FAST  = 8'h0b;
    localparam logic [7:0] OP_DUAL  = 8'h3b;

    // status byte layout; bit 6 is reserved and reads zero
    localparam int BIT_BUSY = 0;
    localparam int BIT_WEL  = 1;
    localparam int BIT_BP0  = 2;
    localparam int BIT_BP1  = 3;
    localparam int BIT_BP2  = 4;
    localparam int BIT_TB   = 5;
    localparam int BIT_LOCK = 7;

    // index of each field inside the 5-bit protection store
    localparam int PR_BP0  = 0;
    localparam int PR_BP2  = 2;
    localparam int PR_TB   = 3;
    localparam int PR_LOCK = 4;
    localparam logic [4:0] PROT_RESET = 5'h00;

    // rising-edge counts inside a frame
    localparam logic [5:0] CNT_OPC_LAST  = 6'h07;
    localparam logic [5:0] CNT_DATA_LAST = 6'h0f;
    localparam logic [5:0] CNT_ADDR_LO   = 6'h08;
    localparam logic [5:0] CNT_ADDR_HI   = 6'h1f;
    localparam logic [5:0] CNT_MAX       = 6'h3f;
    localparam logic [5:0] LEN_OPCODE    = 6'h08;
    localparam logic [5:0] LEN_WRSR      = 6'h10;
    localparam logic [5:0] START_STATUS  = 6'h08;
    localparam logic [5:0] START_READ    = 6'h20;
    localparam logic [5:0] START_FAST    = 6'h28;

    // output phases per byte: single line and dual line
    localparam logic [2:0] PH_LAST_SINGLE = 3'h7;
    localparam logic [2:0] PH_LAST_DUAL   = 3'h3;

    // timing
    localparam int CLK_PERIOD_NS       = 100;
    localparam int VOL_REFRESH_TIME_NS = 1000;
    localparam int VOL_REFRESH_CYC_RAW = VOL_REFRESH_TIME_NS / CLK_PERIOD_NS;
    localparam int VOL_REFRESH_CYC     = (VOL_REFRESH_CYC_RAW < 1) ? 1
                                         : VOL_REFRESH_CYC_RAW;

endpackage : sfc_pkg

// *** sfc_sync.sv ***
/*
 * two-flop synchroniser for a bundle of quasi-static levels.
 * assumes each bit is a level that holds long enough to be seen; a
 * multi-bit word is only safe when its bits are stable while sampled.
 */
`timescale 1ns/10ps
`default_nettype none

module sfc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);

    logic [W-1:0] meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        meta_r <= d;
        q      <= meta_r;
    end

endmodule : sfc_sync

`default_nettype wire

// *** sfc_core.sv ***
/*
 * serial flash instruction core: write enable latch, status register
 * read and write with locking, normal, fast and dual-output reads.
 * assumes a mode-0 spi host owning spi_clk and cs_b; the host keeps
 * cs_b high for at least four clk periods between frames.
 */
// Behaviour
// - write-enable opcode sets the latch
// - writes need the latch set first
// - volatile enable arms next status write only
// - write-disable clears latch and volatile arming
// - latch cleared at reset and write completion
// - status byte shifted out msb first
// - status read always allowed, repeats until deselect
// - only bits 7,5,4,3,2 are writable
// - status write needs deselect on byte boundary
// - non-volatile write holds busy, then clears latch
// - lock bit with low protect pin blocks writes
// - protect bits reject writes to protected areas
// - volatile write applies quickly with busy low
// - normal read: opcode, 24-bit address, data out
// - read address increments, streams until deselect
// - reads while busy are ignored
// - fast read has eight ignored dummy clocks
// - dual read drives two lines per clock
// - line 1 carries odd bits, line 0 even
// - while busy only status read is served
// - frame starts at select, opcode first
`timescale 1ns/10ps
`default_nettype none

module sfc_core
    import sfc_pkg::*;
#(
    parameter int ADDR_W               = 19,
    parameter int STATUS_WRITE_TIME_US = 15000
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              spi_clk,
    input  wire logic              cs_b,
    input  wire logic              serial_input_line,
    input  wire logic              wp_b,
    output var  logic              dual_line_0_out,
    output var  logic              dual_line_0_oe,
    output var  logic              dual_line_1_out,
    output var  logic              dual_line_1_oe,
    input  wire logic              ext_busy,
    input  wire logic              ext_done,
    input  wire logic [ADDR_W-1:0] chk_addr,
    output var  logic              chk_allowed,
    input  wire logic              mem_we,
    input  wire logic [ADDR_W-1:0] mem_waddr,
    input  wire logic [7:0]        mem_wdata,
    output var  logic              write_enable_latch,
    output var  logic              busy,
    output var  logic              status_lock_bit,
    output var  logic              top_bottom_select,
    output var  logic              protect_range_bit2,
    output var  logic              protect_range_bit1,
    output var  logic              protect_range_bit0
);

    // elaboration check: the address must fit the 24-bit link address
    if (ADDR_W < 8 || ADDR_W > 24) begin : g_bad_addr_w
        $error("sfc_core: ADDR_W must lie between 8 and 24");
    end

    localparam int TW_CYC = (STATUS_WRITE_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                            / CLK_PERIOD_NS;
    localparam int WAIT_MAX = (TW_CYC > VOL_REFRESH_CYC) ? TW_CYC
                              : VOL_REFRESH_CYC;
    localparam int WAIT_W = $clog2(WAIT_MAX + 1);
    localparam logic [WAIT_W-1:0] TW_LOAD  = WAIT_W'(TW_CYC - 1);
    // the refresh window runs from the cs rise and the crossing alone uses
    // up to three clk of it, so volatile bits go in on the next cycle
    localparam logic [WAIT_W-1:0] VOL_LOAD = '0;
    localparam logic [ADDR_W:0]   BYTES    = (ADDR_W+1)'(1) << ADDR_W;

    typedef enum logic [1:0] {ST_IDLE, ST_NV_WR, ST_VOL_WR} sfc_state_t;

    // the array; written by the program path on clk, read by the link
    logic [7:0] mem [2**ADDR_W];

    // ---------------- system clock domain state ----------------
    sfc_state_t        state_r, state_nxt;
    logic [WAIT_W-1:0] wait_r, wait_nxt;
    logic [4:0]        prot_r, prot_nxt;
    logic [4:0]        pend_r, pend_nxt;
    logic              wel_r, wel_nxt;
    logic              varm_r, varm_nxt;
    logic              busy_r, busy_nxt;
    logic              allow_r;
    logic              cs_d_r;
    logic              tog_seen_r;
    logic [7:0]        status_r;

    // ---------------- link domain state ----------------
    logic [5:0]        cnt_r;
    logic [2:0]        ph_r;
    logic [6:0]        shift_r;
    logic [23:0]       addr_r;
    logic [7:0]        op_hold_r;
    logic [7:0]        data_hold_r;
    logic [5:0]        len_hold_r;
    // no reset reaches this domain while spi_clk is idle, so the frame
    // toggle starts from a power-up value instead
    logic              tog_r = 1'b0;

    // crossings: frame info into clk, status byte into the link
    logic [2:0]        sys_sync;
    logic [7:0]        status_link;
    wire               wp_s  = sys_sync[2];
    wire               cs_s  = sys_sync[1];
    wire               tog_s = sys_sync[0];

    sfc_sync #(.W(3)) u_sync_sys (
        .clk (clk),
        .d   ({wp_b, cs_b, tog_r}),
        .q   (sys_sync)
    );

    // status bits are quasi-static; by the first output edge eight
    // link edges have passed, so the synchronised copy has settled
    sfc_sync #(.W(8)) u_sync_link (
        .clk (spi_clk),
        .d   (status_r),
        .q   (status_link)
    );

    // =========================== link side ===========================

    wire [7:0] in_byte = {shift_r, serial_input_line};
    wire [5:0] cnt_sat = (cnt_r == CNT_MAX) ? cnt_r : cnt_r + 6'h01;

    // opcode decode for the current frame (valid once eight bits are in)
    wire is_rdsr = (op_hold_r == OP_RDSR);
    wire is_read = (op_hold_r == OP_READ);
    wire is_dual = (op_hold_r == OP_DUAL);
    wire is_fast = (op_hold_r == OP_FAST) || is_dual;
    wire busy_link = status_link[BIT_BUSY];

    // array reads are dropped while a write cycle runs
    wire rd_op = is_rdsr
               || ((is_read || is_fast) && !busy_link);
    wire [5:0] start = is_rdsr ? START_STATUS
                     : is_read ? START_READ
                     : START_FAST;
    wire in_data = rd_op && (cnt_r >= start) && (cnt_r >= START_STATUS);
    wire [2:0] ph_last = is_dual ? PH_LAST_DUAL : PH_LAST_SINGLE;
    wire       ph_wrap = (ph_r == ph_last);
    wire in_addr = (cnt_r >= CNT_ADDR_LO) && (cnt_r <= CNT_ADDR_HI);

    // next phase within the output byte
    wire [2:0] ph_nxt = !in_data ? ph_r
                      : ph_wrap  ? 3'h0
                      : ph_r + 3'h1;

    // address: shifted in after the opcode, then stepped per byte
    wire [23:0] addr_nxt = in_addr ? {addr_r[22:0], serial_input_line}
                         : (in_data && ph_wrap && !is_rdsr)
                           ? addr_r + 24'h000001
                         : addr_r;

    // bit counters restart with every frame; cs_b high ends the frame
    always_ff @(posedge spi_clk or posedge cs_b) begin
        if (cs_b) begin
            cnt_r <= 6'h00;
            ph_r  <= 3'h0;
        end else begin
            cnt_r <= cnt_sat;
            ph_r  <= ph_nxt;
        end
    end

    // frame capture; these hold after the frame for the clk side
    always_ff @(posedge spi_clk) begin
        shift_r    <= in_byte[6:0];
        addr_r     <= addr_nxt;
        len_hold_r <= cnt_sat;
        if (cnt_r == 6'h00) begin
            tog_r <= ~tog_r;
        end
        if (cnt_r == CNT_OPC_LAST) begin
            op_hold_r <= in_byte;
        end
        if (cnt_r == CNT_DATA_LAST) begin
            data_hold_r <= in_byte;
        end
    end

    // byte being shifted out and the bit on each line
    wire [7:0] out_byte = is_rdsr ? status_link
                        : mem[addr_r[ADDR_W-1:0]];
    wire [2:0] idx_hi = is_dual ? 3'h7 - {ph_r[1:0], 1'b0}
                      : 3'h7 - ph_r;
    wire [2:0] idx_lo = idx_hi - 3'h1;

    // outputs change on falling edges; line 0 turns round only at the
    // first data edge, after the host has let go of it
    always_ff @(negedge spi_clk or posedge cs_b) begin
        if (cs_b) begin
            dual_line_1_out <= 1'b0;
            dual_line_1_oe  <= 1'b0;
            dual_line_0_out <= 1'b0;
            dual_line_0_oe  <= 1'b0;
        end else begin
            dual_line_1_out <= out_byte[idx_hi];
            dual_line_1_oe  <= in_data;
            dual_line_0_out <= out_byte[idx_lo];
            dual_line_0_oe  <= in_data && is_dual;
        end
    end

    // ========================= system side ==========================

    // program path writes the array on every mem_we, with no guard against a link read of it
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[mem_waddr] <= mem_wdata;
        end
    end

    // a frame is taken once: at the cs rise after a new frame toggle
    wire frame_end = cs_s && !cs_d_r && (tog_s != tog_seen_r);
    wire idle      = (state_r == ST_IDLE) && !ext_busy;
    wire take      = frame_end && idle;
    wire len_byte  = (len_hold_r == LEN_OPCODE);
    wire len_wrsr  = (len_hold_r == LEN_WRSR);

    // command decode at the end of a frame
    wire wren_go  = take && len_byte && (op_hold_r == OP_WREN);
    wire wrdi_go  = take && len_byte && (op_hold_r == OP_WRDI);
    wire vwren_go = take && len_byte && (op_hold_r == OP_VWREN);
    wire locked   = prot_r[PR_LOCK] && !wp_s;
    wire wrsr_go  = take && len_wrsr && (op_hold_r == OP_WRSR)
                    && (wel_r || varm_r)
                    && !locked;
    wire wait_done = (wait_r == '0);

    // writable fields picked out of the received byte
    wire [4:0] wr_bits = {data_hold_r[BIT_LOCK], data_hold_r[BIT_TB],
                          data_hold_r[BIT_BP2:BIT_BP0]};

    // status write sequencer
    always_comb begin
        state_nxt = state_r;
        wait_nxt  = wait_r;
        prot_nxt  = prot_r;
        pend_nxt  = pend_r;
        unique case (state_r)
            ST_IDLE: begin
                if (wrsr_go) begin
                    pend_nxt = wr_bits;
                    if (varm_r) begin
                        state_nxt = ST_VOL_WR;
                        wait_nxt  = VOL_LOAD;
                    end else begin
                        state_nxt = ST_NV_WR;
                        wait_nxt  = TW_LOAD;
                    end
                end
            end
            ST_NV_WR, ST_VOL_WR: begin
                if (wait_done) begin
                    prot_nxt  = pend_r;
                    state_nxt = ST_IDLE;
                end else begin
                    wait_nxt = wait_r - WAIT_W'(1);
                end
            end
        endcase
    end

    // busy only for the non-volatile cycle and outside operations
    assign busy_nxt = (state_nxt == ST_NV_WR) || ext_busy;

    // latch: clears first, a same-cycle set still wins
    wire nv_done = (state_r == ST_NV_WR) && wait_done;
    always_comb begin
        wel_nxt = wel_r;
        if (wrdi_go || nv_done || ext_done) begin
            wel_nxt = 1'b0;
        end
        if (wren_go) begin
            wel_nxt = 1'b1;
        end
    end

    // volatile arming: consumed by the next accepted status write
    always_comb begin
        varm_nxt = varm_r;
        if (wrdi_go || wrsr_go) begin
            varm_nxt = 1'b0;
        end
        if (vwren_go) begin
            varm_nxt = 1'b1;
        end
    end

    // protected range: zero none, seven all, else a power-of-two slice
    wire [2:0] bp = prot_r[PR_BP2:PR_BP0];
    wire [ADDR_W:0] prot_size = BYTES >> (3'h7 - bp);
    wire [ADDR_W:0] addr_ext  = {1'b0, chk_addr};
    wire in_top    = addr_ext >= (BYTES - prot_size);
    wire in_bottom = addr_ext < prot_size;
    wire prot_hit  = (bp == 3'h7) || ((bp != 3'h0)
                     && (prot_r[PR_TB] ? in_bottom : in_top));
    wire allow_nxt = wel_r && !busy_r && !prot_hit;

    // status image: busy at bit 0, latch at bit 1, bit 6 reads zero;
    // next protection is shown so busy never falls ahead of new bits
    wire [7:0] status_nxt = {prot_nxt[PR_LOCK], 1'b0, prot_nxt[PR_TB],
                             prot_nxt[PR_BP2:PR_BP0], wel_nxt,
                             busy_nxt};

    // control registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
            wait_r  <= '0;
            prot_r  <= PROT_RESET;
            pend_r  <= PROT_RESET;
            wel_r   <= 1'b0;
            varm_r  <= 1'b0;
            busy_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            wait_r  <= wait_nxt;
            prot_r  <= prot_nxt;
            pend_r  <= pend_nxt;
            wel_r   <= wel_nxt;
            varm_r  <= varm_nxt;
            busy_r  <= busy_nxt;
        end
    end

    // frame tracking and status image
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cs_d_r     <= 1'b1;
            tog_seen_r <= 1'b0;
            status_r   <= 8'h00;
            allow_r    <= 1'b0;
        end else begin
            cs_d_r   <= cs_s;
            status_r <= status_nxt;
            allow_r  <= allow_nxt;
            if (frame_end) begin
                tog_seen_r <= tog_s;
            end
        end
    end

    // outputs to the rest of the unit, all straight from flops
    assign write_enable_latch = wel_r;
    assign busy               = busy_r;
    assign chk_allowed        = allow_r;
    assign status_lock_bit    = prot_r[PR_LOCK];
    assign top_bottom_select  = prot_r[PR_TB];
    assign protect_range_bit2 = prot_r[PR_BP2];
    assign protect_range_bit1 = prot_r[PR_BP0 + 1];
    assign protect_range_bit0 = prot_r[PR_BP0];

endmodule : sfc_core

`default_nettype wire

// *** sfc_core_props.sv ***
/* assertion checker for sfc_core: busy, latch, protection and link drive.
   assumes it is bound into sfc_core from the bench top file. */
`timescale 1ns/10ps
`default_nettype none
module sfc_core_props
    import sfc_pkg::*;
#(
    parameter int ADDR_W               = 19,
    parameter int STATUS_WRITE_TIME_US = 15000
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic spi_clk,
    input  wire logic cs_b,
    input  wire logic dual_line_0_oe,
    input  wire logic dual_line_1_oe,
    input  wire logic ext_busy,
    input  wire logic ext_done,
    input  wire logic chk_allowed,
    input  wire logic write_enable_latch,
    input  wire logic busy,
    input  wire logic status_lock_bit,
    input  wire logic top_bottom_select,
    input  wire logic protect_range_bit2,
    input  wire logic protect_range_bit1,
    input  wire logic protect_range_bit0
);
    logic [5:0] edge_cnt_r;
    logic [2:0] ext_hist_r;
    logic [4:0] prot;
    // rising edges in the frame; deselect clears it at once
    always_ff @(posedge spi_clk or posedge cs_b) begin
        if (cs_b)
            edge_cnt_r <= 6'h00;
        else if (edge_cnt_r != CNT_MAX)
            edge_cnt_r <= edge_cnt_r + 6'h01;
    end
    // history keeps the lag of the external busy out of the status checks
    always_ff @(posedge clk) begin
        ext_hist_r <= {ext_hist_r[1:0], ext_busy};
    end
    assign prot = {status_lock_bit, top_bottom_select, protect_range_bit2,
                   protect_range_bit1, protect_range_bit0};
    // a write cycle never lasts under ten clk, so eight is safe
    sequence nv_busy_s;
        busy [*8];
    endsequence
    busy_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(busy) && !ext_busy && ext_hist_r == 3'h0 |-> nv_busy_s)
        else $error("status write cycle ended too early");
    nv_done_a: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(busy) && !ext_busy && ext_hist_r == 3'h0 |-> !write_enable_latch)
        else $error("latch still set after status write cycle");
    prot_stable_a: assert property (@(posedge clk) disable iff (!rst_b)
        busy && $past(busy) |-> $stable(prot))
        else $error("protection bits moved while busy");
    done_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
        ext_done |=> !write_enable_latch)
        else $error("latch not cleared by completion");
    chk_block_a: assert property (@(posedge clk) disable iff (!rst_b)
        !write_enable_latch || busy || prot[2:0] == 3'h7 |=> !chk_allowed)
        else $error("program allowed without latch or in protected area");
    ext_busy_a: assert property (@(posedge clk) disable iff (!rst_b)
        ext_busy [*3] |-> busy)
        else $error("busy low during external operation");
    deselect_off_a: assert property (@(posedge clk) disable iff (!rst_b)
        cs_b && $past(cs_b) |-> !dual_line_0_oe && !dual_line_1_oe)
        else $error("output driven while deselected");
    opcode_quiet_a: assert property (@(negedge spi_clk) disable iff (cs_b)
        edge_cnt_r < START_STATUS |-> !dual_line_1_oe)
        else $error("line 1 driven before opcode complete");
    dual_late_a: assert property (@(negedge spi_clk) disable iff (cs_b)
        edge_cnt_r < START_FAST |-> !dual_line_0_oe)
        else $error("line 0 driven before dual data phase");
    dual_pair_a: assert property (@(negedge spi_clk) disable iff (cs_b)
        dual_line_0_oe |-> dual_line_1_oe)
        else $error("line 0 driven without line 1");
endmodule : sfc_core_props
`default_nettype wire

// *** sfc_host.sv ***
/* host spi controller model, mode 0, 32 ns link clock that stands low
   between frames. assumes the bench calls xfer one frame at a time. */
`timescale 1ns/10ps
`default_nettype none
module sfc_host (
    output var  logic spi_clk,
    output var  logic cs_b,
    output wire logic serial_input_line,
    input  wire logic dual_line_0_out,
    input  wire logic dual_line_0_oe,
    input  wire logic dual_line_1_out,
    input  wire logic dual_line_1_oe
);
    logic host_val;
    logic l1_seen;
    // shared line 0: the device wins while it drives
    assign serial_input_line = dual_line_0_oe ? dual_line_0_out : host_val;
    initial begin
        spi_clk  = 1'b0;
        host_val = 1'b0;
        l1_seen  = 1'b0;
        // a late rise gives the device's deselect clear a real edge
        #1 cs_b  = 1'b1;
    end
    // one frame: ntx bits msb first, then nrx clocks of answer
    task automatic xfer(input logic [39:0] tx, input int ntx, input int nrx,
                        input logic dual, output logic [15:0] rx,
                        output logic saw_oe);
        int i;
        rx     = 16'h0000;
        saw_oe = 1'b0;
        cs_b   = 1'b0;
        for (i = 0; i < ntx + nrx; i++) begin
            if (dual && i >= 32)
                host_val = ~host_val;
            else if (i < ntx)
                host_val = tx[39-i];
            #16 spi_clk = 1'b1;
            // an undriven line 1 reads as a changing pattern
            l1_seen = dual_line_1_oe ? dual_line_1_out : ~l1_seen;
            if (i >= ntx && dual)
                rx = {rx[13:0], l1_seen, serial_input_line};
            else if (i >= ntx)
                rx = {rx[14:0], l1_seen};
            saw_oe = saw_oe | dual_line_0_oe | dual_line_1_oe;
            #16 spi_clk = 1'b0;
        end
        #16 cs_b = 1'b1;
        #500;  // deselect gap above the 400 ns minimum
    endtask : xfer
endmodule : sfc_host
`default_nettype wire

// *** tb_serial_flash_cmd_status_read.sv ***
/* bench for sfc_core: sfc_host drives the link, the bench drives system
   inputs on the falling clk edge and compares status and data bytes.
   assumes sfc_core_props is bound in at the foot of this file. */
`timescale 1ns/10ps
`default_nettype none
module tb_serial_flash_cmd_status_read;
    import sfc_pkg::*;
    localparam int ADDR_W = 10;
    localparam int TW_US  = 2;     // write cycle of 20 clk keeps runs short
    localparam int LIMIT  = 6000;
    logic              clk, rst_b, spi_clk, cs_b, wp_b, ext_busy, ext_done;
    logic              mem_we, chk_allowed, write_enable_latch, busy;
    logic              l0_out, l0_oe, l1_out, l1_oe, saw;
    logic [ADDR_W-1:0] chk_addr, mem_waddr;
    logic [7:0]        mem_wdata;
    logic [15:0]       rx;
    wire logic         serial_input_line;
    int                failures = 0;
    int                n_checks = 0;
    int                cycles   = 0;
    logic [7:0]        dat [4] = '{8'ha5, 8'h3c, 8'h0f, 8'h81};
    sfc_core #(.ADDR_W(ADDR_W), .STATUS_WRITE_TIME_US(TW_US)) sfc_core_inst (
        .clk(clk), .rst_b(rst_b), .spi_clk(spi_clk), .cs_b(cs_b),
        .serial_input_line(serial_input_line), .wp_b(wp_b),
        .dual_line_0_out(l0_out), .dual_line_0_oe(l0_oe),
        .dual_line_1_out(l1_out), .dual_line_1_oe(l1_oe),
        .ext_busy(ext_busy), .ext_done(ext_done), .chk_addr(chk_addr),
        .chk_allowed(chk_allowed), .mem_we(mem_we), .mem_waddr(mem_waddr),
        .mem_wdata(mem_wdata), .write_enable_latch(write_enable_latch),
        .busy(busy), .status_lock_bit(), .top_bottom_select(),
        .protect_range_bit2(), .protect_range_bit1(), .protect_range_bit0());
    sfc_host sfc_host_inst (
        .spi_clk(spi_clk), .cs_b(cs_b), .serial_input_line(serial_input_line),
        .dual_line_0_out(l0_out), .dual_line_0_oe(l0_oe),
        .dual_line_1_out(l1_out), .dual_line_1_oe(l1_oe));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    // a hung handshake must still reach the report
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failures++;
            summarize();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cmd(input logic [39:0] tx, input int ntx, input int nrx,
                       input logic dual);
        sfc_host_inst.xfer(tx, ntx, nrx, dual, rx, saw);
        // later pin checks and stimulus then sit on a settled falling edge
        @(negedge clk);
    endtask : cmd
    task automatic op(input logic [7:0] code);
        cmd({code, 32'h0}, 8, 0, 1'b0);
    endtask : op
    task automatic wrsr(input logic [7:0] v, input int n);
        cmd({OP_WRSR, v, 24'h0}, n, 0, 1'b0);
    endtask : wrsr
    // two bytes read back, so the repeat is seen every time
    task automatic rdsr(input logic [7:0] exp);
        cmd({OP_RDSR, 32'h0}, 8, 16, 1'b0);
        chk(rx, {exp, exp});
    endtask : rdsr
    task automatic wait_idle;
        int i;
        for (i = 0; i < 200 && busy !== 1'b0; i++) @(negedge clk);
        chk({15'h0, busy}, 16'h0);
    endtask : wait_idle
    initial begin
        rst_b = 1'b0;
        wp_b = 1'b1;
        ext_busy = 1'b0;
        ext_done = 1'b0;
        mem_we = 1'b0;
        mem_waddr = '0;
        mem_wdata = 8'h00;
        chk_addr = '0;
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            mem_we = 1'b1;
            mem_waddr = ADDR_W'(32 + i);
            mem_wdata = dat[i];
        end
        @(negedge clk) mem_we = 1'b0;
        rdsr(8'h00);
        op(OP_WREN);
        rdsr(8'h02);
        op(OP_WRDI);
        rdsr(8'h00);
        wrsr(8'hff, 16);
        rdsr(8'h00);
        op(OP_WREN);
        wrsr(8'hff, 17);
        rdsr(8'h02);
        wrsr(8'hff, 16);
        chk({15'h0, busy}, 16'h1);
        rdsr(8'h03);
        wait_idle();
        rdsr(8'hbc);
        @(negedge clk) wp_b = 1'b0;
        op(OP_WREN);
        wrsr(8'h00, 16);
        wait_idle();
        rdsr(8'hbe);
        @(negedge clk) wp_b = 1'b1;
        wrsr(8'h00, 16);
        wait_idle();
        rdsr(8'h00);
        op(OP_VWREN);
        rdsr(8'h00);
        wrsr(8'h1c, 16);
        chk({15'h0, busy}, 16'h0);
        rdsr(8'h1c);
        wrsr(8'h00, 16);
        rdsr(8'h1c);
        op(OP_VWREN);
        op(OP_WRDI);
        wrsr(8'h00, 16);
        rdsr(8'h1c);
        op(OP_WREN);
        chk({15'h0, chk_allowed}, 16'h0);
        @(negedge clk) ext_done = 1'b1;
        @(negedge clk) ext_done = 1'b0;
        chk({15'h0, write_enable_latch}, 16'h0);
        op(OP_VWREN);
        wrsr(8'h00, 16);
        op(OP_WREN);
        repeat (2) @(negedge clk);
        chk({15'h0, chk_allowed}, 16'h1);
        @(negedge clk) ext_busy = 1'b1;
        op(OP_WRDI);
        cmd({OP_READ, 24'h20, 8'h0}, 32, 16, 1'b0);
        chk({15'h0, saw}, 16'h0);
        rdsr(8'h03);
        @(negedge clk) ext_busy = 1'b0;
        cmd({OP_READ, 24'h20, 8'h0}, 32, 16, 1'b0);
        chk(rx, {dat[0], dat[1]});
        cmd({OP_FAST, 24'h21, 8'hff}, 40, 16, 1'b0);
        chk(rx, {dat[1], dat[2]});
        cmd({OP_DUAL, 24'h22, 8'hff}, 40, 8, 1'b1);
        chk(rx, {dat[2], dat[3]});
        summarize();
    end
endmodule : tb_serial_flash_cmd_status_read
bind sfc_core sfc_core_props #(
    .ADDR_W(ADDR_W), .STATUS_WRITE_TIME_US(STATUS_WRITE_TIME_US)
) sfc_core_props_inst (
    .clk(clk), .rst_b(rst_b), .spi_clk(spi_clk), .cs_b(cs_b),
    .dual_line_0_oe(dual_line_0_oe), .dual_line_1_oe(dual_line_1_oe),
    .ext_busy(ext_busy), .ext_done(ext_done), .chk_allowed(chk_allowed),
    .write_enable_latch(write_enable_latch), .busy(busy),
    .status_lock_bit(status_lock_bit), .top_bottom_select(top_bottom_select),
    .protect_range_bit2(protect_range_bit2),
    .protect_range_bit1(protect_range_bit1),
    .protect_range_bit0(protect_range_bit0));
`default_nettype wire
